// ==== hw/pmr_gain_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmr_params.svh"
// combinational decode of the gain setup byte
module pmr_gain_decode (
  // gain setup byte
  input  wire logic [7:0]         gain_setup,
  // decoded resolution and gain factors
  output var  pmr_pkg::pmr_gain_t dec
);
  logic [2:0] bus_code;  // bus gain code after saturation
  // codes above the top step saturate
  always_comb begin
    bus_code = gain_setup[`PMR_GAIN_BG_MSB:`PMR_GAIN_BG_LSB];
    if (bus_code > `PMR_BGAIN_MAXCODE) begin
      bus_code = `PMR_BGAIN_MAXCODE;
    end
    dec.sense_resolution_select = gain_setup[`PMR_GAIN_SRES];
    dec.bus_resolution_select   = gain_setup[`PMR_GAIN_BRES];
    dec.current_digital_gain    = 8'h01 << gain_setup[`PMR_GAIN_CG_MSB:`PMR_GAIN_CG_LSB];
    dec.bus_digital_gain        = 6'h01 << bus_code;
  end
endmodule // pmr_gain_decode
`default_nettype wire

// ==== hw/pmr_params.svh ====
// Behaviour
// - block write stores bytes into consecutive registers
// - block read returns consecutive bytes until host nack
// - unused register bits always read as zero
// - multi-byte results frozen after settling outside integrate
// - gain bit 7 picks sense resolution 11/14
// - gain bit 6 picks bus resolution 11/14
// - current gain field gives two to the code
// - bus gain field saturates at 32x
// - wrong address or bad sequence: ignored, unchanged
// - stop resets the client interface
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH

// ==================================================================
// register offsets
`define PMR_OFS_GAIN      8'h00
`define PMR_OFS_INTEG     8'h01
`define PMR_OFS_CTRL      8'h02
`define PMR_OFS_VBUS_HI   8'h10
`define PMR_OFS_VBUS_LO   8'h11
`define PMR_OFS_VSNS_HI   8'h12
`define PMR_OFS_VSNS_LO   8'h13
`define PMR_OFS_BSUM3     8'h14
`define PMR_OFS_BSUM2     8'h15
`define PMR_OFS_BSUM1     8'h16
`define PMR_OFS_BSUM0     8'h17
`define PMR_OFS_CSUM3     8'h18
`define PMR_OFS_CSUM2     8'h19
`define PMR_OFS_CSUM1     8'h1a
`define PMR_OFS_CSUM0     8'h1b
`define PMR_OFS_OVF       8'h1c
`define PMR_OFS_PWR_HI    8'h1d
`define PMR_OFS_PWR_LO    8'h1e
`define PMR_OFS_SMP_HI    8'h21
`define PMR_OFS_SMP_LO    8'h22
`define PMR_OFS_PSUM4     8'h23
`define PMR_OFS_PSUM3     8'h24
`define PMR_OFS_PSUM2     8'h25
`define PMR_OFS_PSUM1     8'h26
`define PMR_OFS_PSUM0     8'h27
`define PMR_OFS_PART      8'hfd
`define PMR_OFS_MAKER     8'hfe
`define PMR_OFS_REV       8'hff

// ==================================================================
// reset values of the writable registers
`define PMR_RST_GAIN      8'h00
`define PMR_RST_INTEG     8'h0c
`define PMR_RST_CTRL      8'h00

// ==================================================================
// gain register fields and limits
`define PMR_GAIN_SRES     7
`define PMR_GAIN_BRES     6
`define PMR_GAIN_CG_MSB   5
`define PMR_GAIN_CG_LSB   3
`define PMR_GAIN_BG_MSB   2
`define PMR_GAIN_BG_LSB   0
`define PMR_BGAIN_MAXCODE 3'h5

// ==================================================================
// timing
`define PMR_CLK_PERIOD_NS 50
`define PMR_SETTLE_NS     1000
`define PMR_SETTLE_CYC    ((`PMR_SETTLE_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS)

`endif

// ==== hw/pmr_pkg.sv ====
`default_nettype none
package pmr_pkg;
  // ================================================================
  // serial client states, one-hot
  typedef enum logic [9:0] {
    PMR_IDLE   = 10'h001,
    PMR_ADDR   = 10'h002,
    PMR_AACK   = 10'h004,
    PMR_REG    = 10'h008,
    PMR_DACK   = 10'h010,
    PMR_WDATA  = 10'h020,
    PMR_RDATA  = 10'h040,
    PMR_RACK   = 10'h080,
    PMR_RNEXT  = 10'h100,
    PMR_IGNORE = 10'h200
  } pmr_fsm_t;
  // state of the measurement engine
  typedef enum logic [1:0] {
    PMR_MS_INTEGRATE = 2'h0,
    PMR_MS_READ      = 2'h1,
    PMR_MS_SLEEP     = 2'h2
  } pmr_mstate_t;
  // results delivered by the measurement engine
  typedef struct packed {
    logic [9:0]  vbus;
    logic [9:0]  vsense;
    logic [24:0] bus_sum;
    logic [24:0] current_sum;
    logic [2:0]  ovf;
    logic [9:0]  power;
    logic [11:0] samples;
    logic [38:0] power_sum;
  } pmr_meas_t;
  // writable configuration bytes
  typedef struct packed {
    logic [7:0] gain_setup;
    logic [7:0] integration_setup;
    logic [7:0] control;
  } pmr_cfg_t;
  // decoded gain setup
  typedef struct packed {
    logic       sense_resolution_select;
    logic       bus_resolution_select;
    logic [7:0] current_digital_gain;
    logic [5:0] bus_digital_gain;
  } pmr_gain_t;
endpackage
`default_nettype wire

// ==== hw/pmr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin inputs
module pmr_sync #(
  parameter int unsigned     W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  // asynchronous level in, synchronised level out
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);
  typedef struct packed {
    logic [W-1:0] s1;  // first stage, read only by s2
    logic [W-1:0] s2;  // second stage
  } pmr_sync_st_t;
  pmr_sync_st_t st_q;
  pmr_sync_st_t st_d;
  // next state
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  // registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q <= {RST, RST};
    end else begin
      st_q <= st_d;
    end
  end
  assign q = st_q.s2;
endmodule // pmr_sync
`default_nettype wire

// ==== hw/pmr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmr_params.svh"
// register file of the power monitor behind a two-wire serial client
module pmr_top #(
  parameter int unsigned SETTLE_CYC = `PMR_SETTLE_CYC,
  parameter logic [7:0]  PART_CODE  = 8'h11,  // arbitrary value
  parameter logic [7:0]  MAKER_CODE = 8'h22,  // arbitrary value
  parameter logic [7:0]  REV_CODE   = 8'h01   // arbitrary value
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // two-wire bus pins, open drain
  input  wire logic                 scl,
  input  wire logic                 sda,
  output logic                      sda_level,
  output logic                      sda_oe,
  // client address strap
  input  wire logic [6:0]           dev_addr,
  // measurement engine
  input  wire pmr_pkg::pmr_mstate_t meas_state,
  input  wire pmr_pkg::pmr_meas_t   meas,
  // configuration towards the engine
  output var  pmr_pkg::pmr_cfg_t    cfg,
  output var  pmr_pkg::pmr_gain_t   gain
);

  // ================================================================
  // state
  typedef struct packed {
    pmr_pkg::pmr_fsm_t  fsm;      // client sequence
    logic [3:0]         bitcnt;   // bits of current byte seen
    logic [7:0]         shreg;    // incoming byte
    logic [7:0]         tx;       // outgoing byte, msb on the wire
    logic [7:0]         ptr;      // register pointer
    logic               rd;       // direction of current transfer
    logic               sda_oe;   // pulling sda low
    logic               sda_o;    // level driven when enabled
    logic               scl_d;    // scl one cycle ago
    logic               sda_d;    // sda one cycle ago
    pmr_pkg::pmr_cfg_t  cfg;      // writable registers
    pmr_pkg::pmr_gain_t gain;     // registered gain decode
    pmr_pkg::pmr_meas_t shadow;   // results seen by the host
    logic [15:0]        settle;   // cycles left before freezing
  } pmr_top_st_t;

  pmr_top_st_t        st_q;       // registered state
  pmr_top_st_t        st_d;       // next state
  logic [8:0]         pins_s;     // synchronised scl, sda, strap
  logic               scl_s;      // synchronised scl
  logic               sda_s;      // synchronised sda
  logic [6:0]         addr_s;     // synchronised strap
  logic               start_c;    // start seen this cycle
  logic               stop_c;     // stop seen this cycle
  logic               rise_c;     // scl rising edge
  logic               fall_c;     // scl falling edge
  logic               wr_c;       // data byte completed, write side
  pmr_pkg::pmr_gain_t gain_c;     // combinational gain decode

  localparam logic [15:0] SETTLE_W = 16'(SETTLE_CYC);

  // ================================================================
  // pin synchroniser; bus idles high
  pmr_sync #(
    .W   (9),
    .RST ({2'b11, 7'h00})
  ) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({scl, sda, dev_addr}),
    .q       (pins_s)
  );
  assign scl_s  = pins_s[8];
  assign sda_s  = pins_s[7];
  assign addr_s = pins_s[6:0];

  // gain decode for the engine
  pmr_gain_decode u_gain (
    .gain_setup (st_q.cfg.gain_setup),
    .dec        (gain_c)
  );

  // ================================================================
  // bus conditions, taken from the second synchroniser stage only
  assign start_c = st_q.scl_d && scl_s && st_q.sda_d && !sda_s;
  assign stop_c  = st_q.scl_d && scl_s && !st_q.sda_d && sda_s;
  assign rise_c  = !st_q.scl_d && scl_s;
  assign fall_c  = st_q.scl_d && !scl_s;

  // ================================================================
  // read mux; unused bits are forced to zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input pmr_pkg::pmr_cfg_t c,
                                         input pmr_pkg::pmr_meas_t m);
    logic [7:0] b;
    b = 8'h00;
    case (a)
      `PMR_OFS_GAIN:    b = c.gain_setup;
      `PMR_OFS_INTEG:   b = c.integration_setup;
      `PMR_OFS_CTRL:    b = c.control;
      `PMR_OFS_VBUS_HI: b = m.vbus[9:2];
      `PMR_OFS_VBUS_LO: b = {m.vbus[1:0], 6'h00};
      `PMR_OFS_VSNS_HI: b = m.vsense[9:2];
      `PMR_OFS_VSNS_LO: b = {m.vsense[1:0], 6'h00};
      `PMR_OFS_BSUM3:   b = m.bus_sum[24:17];
      `PMR_OFS_BSUM2:   b = m.bus_sum[16:9];
      `PMR_OFS_BSUM1:   b = m.bus_sum[8:1];
      `PMR_OFS_BSUM0:   b = {m.bus_sum[0], 7'h00};
      `PMR_OFS_CSUM3:   b = m.current_sum[24:17];
      `PMR_OFS_CSUM2:   b = m.current_sum[16:9];
      `PMR_OFS_CSUM1:   b = m.current_sum[8:1];
      `PMR_OFS_CSUM0:   b = {m.current_sum[0], 7'h00};
      `PMR_OFS_OVF:     b = {5'h00, m.ovf};
      `PMR_OFS_PWR_HI:  b = m.power[9:2];
      `PMR_OFS_PWR_LO:  b = {m.power[1:0], 6'h00};
      `PMR_OFS_SMP_HI:  b = m.samples[11:4];
      `PMR_OFS_SMP_LO:  b = {m.samples[3:0], 4'h0};
      `PMR_OFS_PSUM4:   b = m.power_sum[38:31];
      `PMR_OFS_PSUM3:   b = m.power_sum[30:23];
      `PMR_OFS_PSUM2:   b = m.power_sum[22:15];
      `PMR_OFS_PSUM1:   b = m.power_sum[14:7];
      `PMR_OFS_PSUM0:   b = {m.power_sum[6:0], 1'b0};
      `PMR_OFS_PART:    b = PART_CODE;
      `PMR_OFS_MAKER:   b = MAKER_CODE;
      `PMR_OFS_REV:     b = REV_CODE;
      default:          b = 8'h00;  // unmapped reads as zero
    endcase
    return b;
  endfunction

  // ================================================================
  // next-state logic
  always_comb begin
    st_d       = st_q;
    wr_c       = 1'b0;
    st_d.scl_d = scl_s;
    st_d.sda_d = sda_s;
    st_d.sda_o = 1'b0;  // open drain: only ever pulls low
    st_d.gain  = gain_c;

    // result snapshot: tracks the engine while it integrates and for
    // the settling window after; frozen otherwise so that a block
    // read of a wide value never mixes two updates
    if (meas_state == pmr_pkg::PMR_MS_INTEGRATE) begin
      st_d.settle = SETTLE_W;
      st_d.shadow = meas;
    end else if (st_q.settle != 16'h0000) begin
      st_d.settle = st_q.settle - 16'h0001;
      st_d.shadow = meas;
    end

    if (start_c) begin
      // start or repeated start; pointer is kept for the read phase
      st_d.fsm    = pmr_pkg::PMR_ADDR;
      st_d.bitcnt = 4'h0;
      st_d.sda_oe = 1'b0;
    end else if (stop_c) begin
      // stop always returns the client to idle
      st_d.fsm    = pmr_pkg::PMR_IDLE;
      st_d.bitcnt = 4'h0;
      st_d.sda_oe = 1'b0;
    end else if (rise_c) begin
      // sample the line on scl rising
      unique case (st_q.fsm)
        pmr_pkg::PMR_ADDR, pmr_pkg::PMR_REG, pmr_pkg::PMR_WDATA: begin
          if (st_q.bitcnt != 4'h8) begin
            st_d.shreg  = {st_q.shreg[6:0], sda_s};
            st_d.bitcnt = st_q.bitcnt + 4'h1;
          end
        end
        pmr_pkg::PMR_RDATA: begin
          st_d.tx     = {st_q.tx[6:0], 1'b0};
          st_d.bitcnt = st_q.bitcnt + 4'h1;
        end
        pmr_pkg::PMR_RACK: begin
          // host nack ends the read; wait for stop
          if (sda_s) begin
            st_d.fsm = pmr_pkg::PMR_IGNORE;
          end else begin
            st_d.fsm = pmr_pkg::PMR_RNEXT;
          end
        end
        pmr_pkg::PMR_IDLE, pmr_pkg::PMR_AACK, pmr_pkg::PMR_DACK,
        pmr_pkg::PMR_RNEXT, pmr_pkg::PMR_IGNORE: begin
          st_d.bitcnt = st_q.bitcnt;
        end
      endcase
    end else if (fall_c) begin
      // drive or release the line on scl falling
      unique case (st_q.fsm)
        pmr_pkg::PMR_ADDR: begin
          if (st_q.bitcnt == 4'h8) begin
            if (st_q.shreg[7:1] == addr_s) begin
              st_d.rd     = st_q.shreg[0];
              st_d.fsm    = pmr_pkg::PMR_AACK;
              st_d.sda_oe = 1'b1;
            end else begin
              // foreign address: stay silent until the next start/stop
              st_d.fsm    = pmr_pkg::PMR_IGNORE;
            end
          end
        end
        pmr_pkg::PMR_REG: begin
          if (st_q.bitcnt == 4'h8) begin
            st_d.ptr    = st_q.shreg;
            st_d.fsm    = pmr_pkg::PMR_DACK;
            st_d.sda_oe = 1'b1;
          end
        end
        pmr_pkg::PMR_WDATA: begin
          if (st_q.bitcnt == 4'h8) begin
            wr_c = 1'b1;
            unique case (st_q.ptr)
              `PMR_OFS_GAIN:  st_d.cfg.gain_setup        = st_q.shreg;
              `PMR_OFS_INTEG: st_d.cfg.integration_setup = st_q.shreg;
              `PMR_OFS_CTRL:  st_d.cfg.control           = st_q.shreg;
              default:        st_d.cfg                   = st_q.cfg;
            endcase
            st_d.ptr    = st_q.ptr + 8'h01;
            st_d.fsm    = pmr_pkg::PMR_DACK;
            st_d.sda_oe = 1'b1;
          end
        end
        pmr_pkg::PMR_AACK: begin
          st_d.bitcnt = 4'h0;
          if (st_q.rd) begin
            // first read byte goes out straight after the address ack
            st_d.tx     = rd_byte(st_q.ptr, st_q.cfg, st_q.shadow);
            st_d.ptr    = st_q.ptr + 8'h01;
            st_d.sda_oe = ~st_d.tx[7];
            st_d.fsm    = pmr_pkg::PMR_RDATA;
          end else begin
            st_d.sda_oe = 1'b0;
            st_d.fsm    = pmr_pkg::PMR_REG;
          end
        end
        pmr_pkg::PMR_DACK: begin
          st_d.bitcnt = 4'h0;
          st_d.sda_oe = 1'b0;
          st_d.fsm    = pmr_pkg::PMR_WDATA;
        end
        pmr_pkg::PMR_RDATA: begin
          if (st_q.bitcnt == 4'h8) begin
            st_d.sda_oe = 1'b0;
            st_d.fsm    = pmr_pkg::PMR_RACK;
          end else begin
            st_d.sda_oe = ~st_q.tx[7];
          end
        end
        pmr_pkg::PMR_RNEXT: begin
          st_d.bitcnt = 4'h0;
          st_d.tx     = rd_byte(st_q.ptr, st_q.cfg, st_q.shadow);
          st_d.ptr    = st_q.ptr + 8'h01;
          st_d.sda_oe = ~st_d.tx[7];
          st_d.fsm    = pmr_pkg::PMR_RDATA;
        end
        pmr_pkg::PMR_IDLE, pmr_pkg::PMR_RACK, pmr_pkg::PMR_IGNORE: begin
          st_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ================================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q                        <= '0;
      st_q.fsm                    <= pmr_pkg::PMR_IDLE;
      st_q.scl_d                  <= 1'b1;
      st_q.sda_d                  <= 1'b1;
      st_q.cfg.gain_setup         <= `PMR_RST_GAIN;
      st_q.cfg.integration_setup  <= `PMR_RST_INTEG;
      st_q.cfg.control            <= `PMR_RST_CTRL;
      st_q.gain.current_digital_gain <= 8'h01;
      st_q.gain.bus_digital_gain  <= 6'h01;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign sda_level = st_q.sda_o;
  assign sda_oe    = st_q.sda_oe;
  assign cfg       = st_q.cfg;
  assign gain      = st_q.gain;

  // ================================================================
  // checks
  AST_STOP_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    stop_c |=> (st_q.fsm == pmr_pkg::PMR_IDLE) && !sda_oe)
    else $error("client not idle after stop");

  AST_FOREIGN_ADDR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (fall_c && st_q.fsm == pmr_pkg::PMR_ADDR && st_q.bitcnt == 4'h8
     && st_q.shreg[7:1] != addr_s && !start_c && !stop_c)
    |=> (st_q.fsm == pmr_pkg::PMR_IGNORE) && !sda_oe && $stable(st_q.cfg))
    else $error("foreign address answered");

  AST_SILENT: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q.fsm == pmr_pkg::PMR_IGNORE) |-> !sda_oe)
    else $error("drove sda while ignoring");

  AST_WRITE_STORE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_c && st_q.ptr == `PMR_OFS_CTRL)
    |=> (cfg.control == $past(st_q.shreg)) && sda_oe)
    else $error("written byte not stored or acked");

  AST_PTR_STEP: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_c |=> st_q.ptr == $past(st_q.ptr) + 8'h01)
    else $error("pointer did not advance");

  AST_RO_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_c && st_q.ptr > `PMR_OFS_CTRL) |=> $stable(st_q.cfg) && sda_oe)
    else $error("read-only write changed config");

  AST_NACK_END: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rise_c && st_q.fsm == pmr_pkg::PMR_RACK && sda_s && !start_c && !stop_c)
    |=> (st_q.fsm == pmr_pkg::PMR_IGNORE) ##1 !sda_oe)
    else $error("read went on after nack");

  AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (fall_c && st_q.fsm == pmr_pkg::PMR_RNEXT && st_q.ptr == `PMR_OFS_VBUS_LO
     && !start_c && !stop_c) |=> st_q.tx[5:0] == 6'h00)
    else $error("unused bits not zero");

  AST_FROZEN: assert property (@(posedge clk_sys) disable iff (!rstn)
    (meas_state != pmr_pkg::PMR_MS_INTEGRATE && st_q.settle == 16'h0000)
    |=> $stable(st_q.shadow))
    else $error("results moved after settling");

  AST_SENSE_RES: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 gain.sense_resolution_select == $past(st_q.cfg.gain_setup[`PMR_GAIN_SRES]))
    else $error("sense resolution mismatch");

  AST_BUS_RES: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 gain.bus_resolution_select == $past(st_q.cfg.gain_setup[`PMR_GAIN_BRES]))
    else $error("bus resolution mismatch");

  AST_CUR_GAIN: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q.cfg.gain_setup[`PMR_GAIN_CG_MSB:`PMR_GAIN_CG_LSB] == 3'h7)
    |=> gain.current_digital_gain == 8'h80)
    else $error("current gain code 7 not 128x");

  AST_BUS_GAIN_SAT: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q.cfg.gain_setup[`PMR_GAIN_BG_MSB:`PMR_GAIN_BG_LSB] >= 3'h5)
    |=> gain.bus_digital_gain == 6'h20)
    else $error("bus gain not saturated at 32x");

endmodule // pmr_top
`default_nettype wire

// ==== tb/pmr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bus host: drives scl, pulls sda or lets the pull-up win
module pmr_host_model (
  // bench clock
  input  wire logic clk_sys,
  // device pull-down
  input  wire logic dev_sda_oe,
  // wired lines
  output logic      scl,
  output wire logic sda
);
  logic sda_rel;  // high: host lets go of sda
  // open drain with pull-up, so a released line reads high
  assign sda = sda_rel & ~dev_sda_oe;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // wait n clocks, then change just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one bit; data moves two clocks after scl fell so it never looks like start or stop
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_rel = b;
    tick(6);
    scl = 1'b1;
    tick(6);
    r = sda;
    scl = 1'b0;
  endtask
  // start or repeated start: sda falls under high scl
  task automatic start_cond();
    tick(2);
    sda_rel = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_rel = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask
  // stop: sda rises under high scl, bus left idle
  task automatic stop_cond();
    tick(2);
    sda_rel = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_rel = 1'b1;
    tick(6);
  endtask
  // one byte msb first, then the ack slot; ack_in high leaves it to the pull-up
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ack_in, ack);
  endtask
endmodule // pmr_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench: register file reached over the two-wire bus
module tb_top;
  localparam logic [6:0] DEV = 7'h4c;  // client address strap
  logic                 clk_sys;
  logic                 rstn;
  wire logic            scl;
  wire logic            sda;
  logic                 sda_o;
  logic                 sda_oe;
  pmr_pkg::pmr_mstate_t meas_state;
  pmr_pkg::pmr_meas_t   meas;
  pmr_pkg::pmr_cfg_t    cfg;
  pmr_pkg::pmr_gain_t   gain;
  int                   errors;
  int                   samples_checked;
  // identity values are arbitrary; short settle ends inside the 10-clock wait of frozen_results
  pmr_top #(.SETTLE_CYC(2), .PART_CODE(8'h3c), .MAKER_CODE(8'h4d), .REV_CODE(8'h07)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .scl(scl), .sda(sda), .sda_level(sda_o), .sda_oe(sda_oe),
    .dev_addr(DEV), .meas_state(meas_state), .meas(meas), .cfg(cfg), .gain(gain));
  pmr_host_model host (.clk_sys(clk_sys), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));
  // ==========================================
  // compare and verdict
  task automatic check(input string what, input logic [119:0] seen, input logic [119:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // bus cycles: block write of n bytes, block read of n bytes
  task automatic wr(input logic [6:0] a, input logic [7:0] ptr, input logic [31:0] d, input int n,
                    input logic ack_exp);
    logic [7:0] rx;
    logic       ack;
    host.start_cond();
    host.xfer({a, 1'b0}, 1'b1, rx, ack);
    check("address ack", ack, ack_exp);
    for (int i = n; i >= 0; i--) begin
      host.xfer((i == n) ? ptr : d[8*i+:8], 1'b1, rx, ack);
      check("byte ack", ack, ack_exp);
    end
    host.stop_cond();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n, output logic [119:0] v);
    logic [7:0] rx;
    logic       ack;
    v = '0;
    host.start_cond();
    host.xfer({DEV, 1'b0}, 1'b1, rx, ack);
    host.xfer(ptr, 1'b1, rx, ack);
    host.start_cond();
    host.xfer({DEV, 1'b1}, 1'b1, rx, ack);
    check("read address ack", ack, 1'b0);
    for (int i = 1; i <= n; i++) begin
      host.xfer(8'hff, i == n, rx, ack);
      v = {v[111:0], rx};
    end
    host.stop_cond();
  endtask
  // ==========================================
  // scenarios
  task automatic reset_values();
    logic [119:0] v;
    check("open drain level", sda_o, 1'b0);
    rd(8'h00, 3, v);
    check("setup after reset", v, 120'h000c00);
  endtask
  // every gain code, both resolution bits each way
  task automatic gain_codes();
    logic [7:0]         g;
    pmr_pkg::pmr_gain_t e;
    for (int c = 0; c < 8; c++) begin
      g = {c[0], ~c[0], c[2:0], c[2:0]};
      wr(DEV, 8'h00, {24'h0, g}, 1, 1'b0);
      e = '{g[7], g[6], 8'(1 << c), 6'(1 << ((c > 5) ? 5 : c))};
      check("gain decode", gain, e);
    end
    wr(DEV, 8'h00, 32'h00a53c81, 3, 1'b0);
    check("block write", cfg, 24'ha53c81);
  endtask
  // foreign address ignored, next transfer after stop accepted
  task automatic wrong_addr();
    wr(DEV ^ 7'h01, 8'h00, 32'h000000ff, 1, 1'b1);
    check("setup after foreign address", cfg, 24'ha53c81);
    wr(DEV, 8'h01, 32'h00000077, 1, 1'b0);
    check("setup after stop", cfg, 24'ha57781);
  endtask
  // leave integrate, settle, then change the engine: reads stay frozen
  task automatic frozen_results();
    logic [119:0] v;
    meas_state = pmr_pkg::PMR_MS_READ;
    repeat (10) @(posedge clk_sys);
    #1 meas = '0;
    rd(8'h10, 15, v);
    check("result block", v, 120'hffc0ffc0ffffff80ffffff8007ffc0);
    rd(8'h1f, 9, v);
    check("sample and power block", v, 120'h0000fff0fffffffffe);
  endtask
  // writes to results dropped; sleep keeps values frozen
  task automatic read_only();
    logic [119:0] v;
    meas_state = pmr_pkg::PMR_MS_SLEEP;
    // values that differ from the frozen results, so a stored write would show
    wr(DEV, 8'h10, 32'h00001234, 2, 1'b0);
    rd(8'h10, 2, v);
    check("read-only result", v, 120'hffc0);
    rd(8'hfd, 4, v);
    check("identity and wrap", v, 120'h3c4d07a5);
  endtask
  // ==========================================
  // clock, watchdog (about three and a half times the expected run), main sequence
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    meas_state = pmr_pkg::PMR_MS_INTEGRATE;
    meas = '1;
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    reset_values();
    gain_codes();
    wrong_addr();
    frozen_results();
    read_only();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
